// ===== logic/pte_pkg.sv
package pte_pkg;

  localparam int NUM_CH   = 8;   // Channels
  localparam int NUM_PINS = 32;  // General-purpose pins

  // Register byte offsets
  localparam logic [11:0] OFS_TASK_OUT    = 12'h000;
  localparam logic [11:0] OFS_TASK_SET    = 12'h004;
  localparam logic [11:0] OFS_TASK_LOW    = 12'h008;
  localparam logic [11:0] OFS_EVENT_IN    = 12'h100; // Plus 4 per channel
  localparam logic [11:0] OFS_EVENT_PORT  = 12'h120;
  localparam logic [11:0] OFS_INTEN       = 12'h200;
  localparam logic [11:0] OFS_INTEN_SET   = 12'h204;
  localparam logic [11:0] OFS_INTEN_OFF   = 12'h208;
  localparam logic [11:0] OFS_CONFIG      = 12'h300; // Plus 4 per channel
  localparam logic [11:0] OFS_SENSE_LO    = 12'h400;
  localparam logic [11:0] OFS_SENSE_HI    = 12'h404;
  localparam logic [11:0] OFS_DETECT_MODE = 12'h408;
  localparam logic [11:0] OFS_LATCH       = 12'h40c;
  localparam logic [11:0] OFS_CH_LEVEL    = 12'h410;

  // Interrupt enable bit of the port event
  localparam int INTEN_PORT_BIT = 31;

  // Reset values
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;

  // Channel modes
  localparam logic [1:0] MODE_DISABLED = 2'h0;
  localparam logic [1:0] MODE_EVENT    = 2'h1;
  localparam logic [1:0] MODE_TASK     = 2'h3;

  // Output action, also the edge choice in event mode
  localparam logic [1:0] POL_NONE   = 2'h0;
  localparam logic [1:0] POL_SET    = 2'h1; // Rising edge in event mode
  localparam logic [1:0] POL_CLEAR  = 2'h2; // Falling edge in event mode
  localparam logic [1:0] POL_TOGGLE = 2'h3; // Any change in event mode

  // Pin sense codes
  localparam logic [1:0] SENSE_OFF  = 2'h0;
  localparam logic [1:0] SENSE_HIGH = 2'h2;
  localparam logic [1:0] SENSE_LOW  = 2'h3;

  // Channel configuration word layout
  typedef struct packed {
    logic [9:0] rsv_hi;               // Bits 31:22, read zero
    logic       initial_output_level; // Bit 21
    logic [2:0] rsv_c;                // Bits 20:18
    logic [1:0] polarity;             // Bits 17:16
    logic [2:0] rsv_b;                // Bits 15:13
    logic [4:0] psel;                 // Bits 12:8
    logic [5:0] rsv_a;                // Bits 7:2
    logic [1:0] mode;                 // Bits 1:0
  } pte_cfg_t;

  // Task triggers from the peripheral interconnect
  typedef struct packed {
    logic [NUM_CH-1:0] out;
    logic [NUM_CH-1:0] drive_low_task;
    logic [NUM_CH-1:0] set;
  } pte_tasks_t;

endpackage

// ===== logic/pte_unit.sv
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
// Pin task and event channels with APB register access
module pte_unit
  import pte_pkg::*;
(
  input  wire logic                clock,
  input  wire logic                srst,
  // APB slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // Task triggers from the peripheral interconnect
  input  wire pte_tasks_t          ic_tasks,
  // Event pulses to the peripheral interconnect
  output logic      [NUM_CH-1:0]   event_in_pulse,
  output logic                     event_port_pulse,
  // General-purpose port settings
  input  wire logic [NUM_PINS-1:0] gp_out,
  input  wire logic [NUM_PINS-1:0] gp_dir,
  // Pads
  input  wire logic [NUM_PINS-1:0] pad_in,
  output logic      [NUM_PINS-1:0] pad_out,
  output logic      [NUM_PINS-1:0] pad_oe,
  // Power management
  input  wire logic                idle_sleep,
  input  wire logic                off_request,
  output logic                     wake_idle,
  output logic                     off_wake_reset,
  output logic                     detect,
  output logic                     irq
);

  // Pad synchroniser stages
  logic [NUM_PINS-1:0] sync_a, sync_b, sync_c;
  logic [NUM_PINS-1:0] pin_state;      // Filtered pin level
  logic [NUM_PINS-1:0] next_pin_state;

  // Channel state
  pte_cfg_t    cfg [NUM_CH];           // Channel configuration
  pte_cfg_t    next_cfg [NUM_CH];
  logic [NUM_CH-1:0] ch_level;         // Channel output level
  logic [NUM_CH-1:0] next_ch_level;
  logic [NUM_CH-1:0] ch_prev;          // Previous sampled pin level
  logic [NUM_CH-1:0] next_ch_prev;
  logic [NUM_CH-1:0] ch_now;           // Current selected pin level
  logic [NUM_CH-1:0] edge_hit;         // Selected edge seen

  // Flags and enables
  logic [NUM_CH-1:0] flag_in, next_flag_in;
  logic              flag_port, next_flag_port;
  logic [31:0]       inten, next_inten;

  // Sense logic
  logic [63:0]         sense, next_sense;     // Two bits per pin
  logic                detect_mode, next_detect_mode; // High selects latch
  logic [NUM_PINS-1:0] latch, next_latch;
  logic [NUM_PINS-1:0] sense_hit;
  logic                rearm, next_rearm;     // Forces one low cycle
  logic                detect_prev, next_detect_prev;
  logic                next_detect;
  logic                next_wake_idle, next_off_wake_reset;
  logic                next_event_port_pulse;
  logic [NUM_CH-1:0]   next_event_in_pulse;

  // Bus decode
  logic        wr_en;                  // Write takes effect this edge
  logic        setup;                  // Setup phase, read data captured
  logic        mapped;
  logic [31:0] rd_value;
  logic [31:0] next_prdata;
  logic [2:0]  idx;                    // Channel index from address

  // Zero wait states: data is captured during setup
  assign pready = 1'b1;
  assign setup  = psel & ~penable;
  assign wr_en  = psel & penable & pwrite & ~pslverr;
  assign idx    = paddr[4:2];

  // Address decode and read mux
  always_comb begin
    mapped   = 1'b1;
    rd_value = RST_ZERO;
    if (paddr[1:0] != 2'h0) begin
      mapped = 1'b0;
    end else if (paddr == OFS_TASK_OUT || paddr == OFS_TASK_SET ||
                 paddr == OFS_TASK_LOW || paddr == OFS_INTEN_OFF) begin
      rd_value = RST_ZERO;
    end else if (paddr[11:5] == OFS_EVENT_IN[11:5]) begin
      rd_value = {31'h0, flag_in[idx]};
    end else if (paddr == OFS_EVENT_PORT) begin
      rd_value = {31'h0, flag_port};
    end else if (paddr == OFS_INTEN || paddr == OFS_INTEN_SET) begin
      rd_value = inten;
    end else if (paddr[11:5] == OFS_CONFIG[11:5]) begin
      rd_value = cfg[idx];
    end else if (paddr == OFS_SENSE_LO) begin
      rd_value = sense[31:0];
    end else if (paddr == OFS_SENSE_HI) begin
      rd_value = sense[63:32];
    end else if (paddr == OFS_DETECT_MODE) begin
      rd_value = {31'h0, detect_mode};
    end else if (paddr == OFS_LATCH) begin
      rd_value = latch;
    end else if (paddr == OFS_CH_LEVEL) begin
      rd_value = {24'h0, ch_level};
    end else begin
      mapped = 1'b0;
    end
    pslverr     = psel & penable & ~mapped;
    next_prdata = setup ? rd_value : prdata;
  end

  // Sense hits per pin, direct level compare
  always_comb begin
    for (int p = 0; p < NUM_PINS; p++) begin
      sense_hit[p] = (sense[2*p +: 2] == SENSE_HIGH &&  pin_state[p]) ||
                     (sense[2*p +: 2] == SENSE_LOW  && !pin_state[p]);
    end
  end

  // Selected pin level and edge per channel
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      ch_now[c] = pin_state[cfg[c].psel];
      case (cfg[c].polarity)
        POL_SET:    edge_hit[c] = ch_now[c] & ~ch_prev[c];
        POL_CLEAR:  edge_hit[c] = ~ch_now[c] & ch_prev[c];
        POL_TOGGLE: edge_hit[c] = ch_now[c] ^ ch_prev[c];
        default:    edge_hit[c] = 1'b0;
      endcase
      edge_hit[c] = edge_hit[c] & (cfg[c].mode == MODE_EVENT);
    end
  end

  // Next state for synchroniser, channels, flags and sense
  always_comb begin
    // three stages, change accepted when two agree
    next_pin_state = pin_state;
    for (int p = 0; p < NUM_PINS; p++) begin
      if (sync_b[p] == sync_c[p]) begin
        next_pin_state[p] = sync_c[p];
      end
    end
    next_ch_prev        = ch_now;
    next_ch_level       = ch_level;
    next_event_in_pulse = edge_hit;
    next_flag_in        = flag_in;
    for (int c = 0; c < NUM_CH; c++) begin
      next_cfg[c] = cfg[c];
      // output first, then clear, then set
      if (cfg[c].mode == MODE_TASK) begin
        if (ic_tasks.out[c]) begin
          // none still wins over set and clear
          case (cfg[c].polarity)
            POL_SET:    next_ch_level[c] = 1'b1;
            POL_CLEAR:  next_ch_level[c] = 1'b0;
            POL_TOGGLE: next_ch_level[c] = ~ch_level[c];
            default:    next_ch_level[c] = ch_level[c];
          endcase
        end else if (ic_tasks.drive_low_task[c]) begin
          next_ch_level[c] = 1'b0;
        end else if (ic_tasks.set[c]) begin
          next_ch_level[c] = 1'b1;
        end
      end
      // Software task triggers, one bit per channel
      if (wr_en && pwdata[c] && cfg[c].mode == MODE_TASK) begin
        if (paddr == OFS_TASK_OUT) begin
          case (cfg[c].polarity)
            POL_SET:    next_ch_level[c] = 1'b1;
            POL_CLEAR:  next_ch_level[c] = 1'b0;
            POL_TOGGLE: next_ch_level[c] = ~ch_level[c];
            default:    next_ch_level[c] = ch_level[c];
          endcase
        end else if (paddr == OFS_TASK_LOW) begin
          next_ch_level[c] = 1'b0;
        end else if (paddr == OFS_TASK_SET) begin
          next_ch_level[c] = 1'b1;
        end
      end
      // Config write; reserved bits stay zero
      if (wr_en && paddr[11:5] == OFS_CONFIG[11:5] && idx == 3'(c)) begin
        next_cfg[c]                      = RST_ZERO;
        next_cfg[c].mode                 = pwdata[1:0];
        next_cfg[c].psel                 = pwdata[12:8];
        next_cfg[c].polarity             = pwdata[17:16];
        next_cfg[c].initial_output_level = pwdata[21];
        // task mode starts at the initial level
        if (pwdata[1:0] == MODE_TASK) begin
          next_ch_level[c] = pwdata[21];
        end
        // Fresh reference so a new edge choice fires no stale event
        next_ch_prev[c] = pin_state[pwdata[12:8]];
      end
      // cleared by writing zero, set wins
      if (wr_en && paddr == OFS_EVENT_IN + {7'h0, 3'(c), 2'h0} && !pwdata[0]) begin
        next_flag_in[c] = 1'b0;
      end
      if (edge_hit[c]) begin
        next_flag_in[c] = 1'b1;
      end
    end

    // Interrupt enables
    next_inten = inten;
    if (wr_en && paddr == OFS_INTEN) begin
      next_inten = pwdata;
    end else if (wr_en && paddr == OFS_INTEN_SET) begin
      next_inten = inten | pwdata;
    end else if (wr_en && paddr == OFS_INTEN_OFF) begin
      next_inten = inten & ~pwdata;
    end
    next_inten[30:NUM_CH] = '0;

    // Sense configuration
    next_sense       = sense;
    next_detect_mode = detect_mode;
    if (wr_en && paddr == OFS_SENSE_LO) begin
      next_sense[31:0] = pwdata;
    end
    if (wr_en && paddr == OFS_SENSE_HI) begin
      next_sense[63:32] = pwdata;
    end
    if (wr_en && paddr == OFS_DETECT_MODE) begin
      next_detect_mode = pwdata[0];
    end

    // Latch: write one clears, a live hit sets again
    next_latch = latch;
    next_rearm = 1'b0;
    if (wr_en && paddr == OFS_LATCH) begin
      next_latch = latch & ~pwdata;
    end
    next_latch = next_latch | sense_hit;
    // partial clear leaves bits, give a new edge
    if (wr_en && paddr == OFS_LATCH && detect_mode && |(latch & pwdata)) begin
      next_rearm = |next_latch;
    end

    // Aggregated sense, held low one cycle on rearm
    next_detect      = (detect_mode ? |latch : |sense_hit) & ~rearm;
    next_detect_prev = detect;
    next_event_port_pulse = detect & ~detect_prev;
    next_flag_port        = flag_port;
    // any write clears
    // Write one clears too, so the masked reconfigure sequence works
    if (wr_en && paddr == OFS_EVENT_PORT) begin
      next_flag_port = 1'b0;
    end
    if (next_event_port_pulse) begin
      next_flag_port = 1'b1;
    end
    // idle wake only from a new rising edge
    next_wake_idle = idle_sleep & next_event_port_pulse;
    // off request while sense high resets
    next_off_wake_reset = off_request & detect;
  end

  // Pin ownership and pad drive
  always_comb begin
    pad_out = gp_out;
    pad_oe  = gp_dir;
    for (int p = 0; p < NUM_PINS; p++) begin
      for (int c = 0; c < NUM_CH; c++) begin
        // one owner assumed; later channel would win
        if (cfg[c].psel == 5'(p)) begin
          if (cfg[c].mode == MODE_EVENT) begin
            pad_oe[p]  = 1'b0;
            pad_out[p] = 1'b0;
          end else if (cfg[c].mode == MODE_TASK) begin
            pad_oe[p]  = 1'b1;
            pad_out[p] = ch_level[c];
          end
        end
      end
    end
  end

  // interrupt while a flag and its enable are set
  assign irq = |(flag_in & inten[NUM_CH-1:0]) | (flag_port & inten[INTEN_PORT_BIT]);

  // Registers; detection keeps no clock-gating request of its own
  // sense path always running
  always_ff @(posedge clock) begin
    sync_a <= pad_in;
    sync_b <= sync_a;
    sync_c <= sync_b;
    if (srst) begin
      pin_state        <= '0;
      ch_level         <= '0;
      ch_prev          <= '0;
      flag_in          <= '0;
      flag_port        <= 1'b0;
      inten            <= RST_ZERO;
      sense            <= '0;
      detect_mode      <= 1'b0;
      latch            <= '0;
      rearm            <= 1'b0;
      detect           <= 1'b0;
      detect_prev      <= 1'b0;
      prdata           <= RST_ZERO;
      event_in_pulse   <= '0;
      event_port_pulse <= 1'b0;
      wake_idle        <= 1'b0;
      off_wake_reset   <= 1'b0;
      for (int c = 0; c < NUM_CH; c++) begin
        cfg[c] <= RST_ZERO;
      end
    end else begin
      pin_state        <= next_pin_state;
      ch_level         <= next_ch_level;
      ch_prev          <= next_ch_prev;
      flag_in          <= next_flag_in;
      flag_port        <= next_flag_port;
      inten            <= next_inten;
      sense            <= next_sense;
      detect_mode      <= next_detect_mode;
      latch            <= next_latch;
      rearm            <= next_rearm;
      detect           <= next_detect;
      detect_prev      <= next_detect_prev;
      prdata           <= next_prdata;
      event_in_pulse   <= next_event_in_pulse;
      event_port_pulse <= next_event_port_pulse;
      wake_idle        <= next_wake_idle;
      off_wake_reset   <= next_off_wake_reset;
      for (int c = 0; c < NUM_CH; c++) begin
        cfg[c] <= next_cfg[c];
      end
    end
  end

endmodule

// ===== test/pte_unit_monitor.sv
`timescale 1ns/1ps
// Port-level watch over the pin task and event channels
module pte_unit_monitor
  import pte_pkg::*;
(
  input wire logic                clock,
  input wire logic                srst,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pslverr,
  input wire logic [NUM_CH-1:0]   event_in_pulse,
  input wire logic                event_port_pulse,
  input wire logic [NUM_PINS-1:0] gp_out,
  input wire logic [NUM_PINS-1:0] gp_dir,
  input wire logic [NUM_PINS-1:0] pad_in,
  input wire logic [NUM_PINS-1:0] pad_out,
  input wire logic [NUM_PINS-1:0] pad_oe,
  input wire logic                off_request,
  input wire logic                wake_idle,
  input wire logic                off_wake_reset,
  input wire logic                detect
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  logic [3:0]          quiet_cnt;      // Cycles the pads held still
  logic [3:0]          next_quiet_cnt; // Saturates so it never wraps
  logic [NUM_PINS-1:0] pad_prev;       // Pads one cycle ago
  // Any pad change restarts the quiet count
  always_comb begin
    if (pad_in != pad_prev) begin
      next_quiet_cnt = 4'h0;
    end else if (quiet_cnt == 4'hf) begin
      next_quiet_cnt = quiet_cnt;
    end else begin
      next_quiet_cnt = quiet_cnt + 4'h1;
    end
  end
  // Register the count and the previous pads
  always_ff @(posedge clock) begin
    pad_prev <= pad_in;
    if (srst) begin
      quiet_cnt <= 4'h0;
    end else begin
      quiet_cnt <= next_quiet_cnt;
    end
  end
  reset_release_a: assert property ($fell(srst) |-> pad_out == gp_out && pad_oe == gp_dir)
    else $error("pads not handed to the port after reset");
  port_pulse_a: assert property ($rose(detect) |=> event_port_pulse)
    else $error("no port event after detect rose");
  port_cause_a: assert property (event_port_pulse |-> $past(detect) && !$past(detect, 2))
    else $error("port event without a detect rise");
  off_wake_a: assert property (off_request && detect |=> off_wake_reset)
    else $error("off request with detect high gave no reset");
  off_cause_a: assert property (off_wake_reset |-> $past(off_request) && $past(detect))
    else $error("off wake reset without cause");
  no_wake_high_a: assert property (detect && $past(detect) && $past(detect, 2) |-> !wake_idle)
    else $error("wake from a detect level already high");
  quiet_pins_a: assert property (quiet_cnt >= 4'h8 |-> event_in_pulse == '0)
    else $error("channel event with pads held still");
  slverr_access_a: assert property (pslverr |-> psel && penable)
    else $error("slave error outside an access phase");
endmodule

bind pte_unit pte_unit_monitor u_mon (
  .clock(clock), .srst(srst), .psel(psel), .penable(penable), .pslverr(pslverr),
  .event_in_pulse(event_in_pulse), .event_port_pulse(event_port_pulse),
  .gp_out(gp_out), .gp_dir(gp_dir), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
  .off_request(off_request), .wake_idle(wake_idle), .off_wake_reset(off_wake_reset),
  .detect(detect)
);

// ===== test/pte_pad_model.sv
`timescale 1ns/1ps
// Far side of the pads: a driven pin reads back its own drive
module pte_pad_model
  import pte_pkg::*;
(
  input  wire logic [NUM_PINS-1:0] pad_out,
  input  wire logic [NUM_PINS-1:0] pad_oe,
  input  wire logic [NUM_PINS-1:0] ext_level,
  output logic      [NUM_PINS-1:0] pad_in
);
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_level);
endmodule

// ===== test/tb.sv
`timescale 1ns/1ps
// Self-checking bench for the pin task and event channels
module tb
  import pte_pkg::*;
;
  logic clock = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic idle_sleep = 1'b0, off_request = 1'b0, rerr, lvl, pready, pslverr;
  logic irq, event_port_pulse, wake_idle, off_wake_reset, detect;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdata, gp_out = 32'h0, gp_dir = 32'h0;
  logic [31:0] ext_level = 32'h0, pad_in, pad_out, pad_oe;
  logic [7:0]  event_in_pulse;
  logic [4:0]  pin, off;
  logic [1:0]  pol;
  logic [2:0]  t;
  pte_tasks_t  ic_tasks = '0, tk;
  integer      seed = 32'ha6c2b3c9;
  int          n_mismatch = 0, n_compared = 0, ce, cp, cw, i, ch, p;

  // 10 MHz system clock
  always #50 clock = ~clock;

  pte_unit u_dut (.clock(clock), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ic_tasks(ic_tasks), .event_in_pulse(event_in_pulse),
    .event_port_pulse(event_port_pulse), .gp_out(gp_out), .gp_dir(gp_dir),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .idle_sleep(idle_sleep),
    .off_request(off_request), .wake_idle(wake_idle), .off_wake_reset(off_wake_reset),
    .detect(detect), .irq(irq));
  pte_pad_model u_pads (.pad_out(pad_out), .pad_oe(pad_oe), .ext_level(ext_level),
    .pad_in(pad_in));

  // Compare and count
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic complete_run();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // One APB transfer; idle edge after it keeps strobes apart
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  // Count pulses over twelve settled samples
  task automatic watch(input int c);
    ce = 0;
    cp = 0;
    cw = 0;
    repeat (12) begin
      @(negedge clock);
      if (event_in_pulse[c] === 1'b1) ce++;
      if (event_port_pulse === 1'b1) cp++;
      if (wake_idle === 1'b1) cw++;
    end
    @(posedge clock);
  endtask

  // Channel configuration word
  function automatic logic [31:0] mk(input logic [1:0] m, input logic [1:0] pl,
                                     input logic [4:0] pn, input logic lv);
    pte_cfg_t c;
    c = '0;
    c.mode = m;
    c.polarity = pl;
    c.psel = pn;
    c.initial_output_level = lv;
    return c;
  endfunction

  // Level after tasks t = {out, clear, set}; output task outranks clear, then set
  function automatic logic nxt(input logic [2:0] tt, input logic [1:0] pl, input logic lv);
    if (tt[2]) return (pl == POL_SET) ? 1'b1 : (pl == POL_CLEAR) ? 1'b0 :
                      (pl == POL_TOGGLE) ? ~lv : lv;
    if (tt[1]) return 1'b0;
    if (tt[0]) return 1'b1;
    return lv;
  endfunction

  // Whether an edge fires the chosen condition
  function automatic logic fires(input logic [1:0] pl, input logic rise);
    return (pl == POL_TOGGLE) || (rise ? (pl == POL_SET) : (pl == POL_CLEAR));
  endfunction

  // Hang guard, far above the several hundred cycles needed
  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    complete_run();
  end

  initial begin
    repeat (6) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    for (i = 0; i < 8; i++) begin
      apb(1'b0, OFS_CONFIG + 12'(4 * i), 32'h0);
      chk("config_reset", rdata, RST_ZERO);
    end
    apb(1'b0, 12'h7fc, 32'h0);
    chk("unmapped_err", {31'h0, rerr}, 32'h1);
    // Task channels, one pin each, random task mixes
    off = 5'($random(seed));
    for (ch = 0; ch < 8; ch++) begin
      pin = off + 5'(ch * 4);
      pol = 2'(ch);
      lvl = 1'($random(seed));
      gp_dir <= $random(seed);
      gp_out <= $random(seed);
      apb(1'b1, OFS_CONFIG + 12'(4 * ch), mk(MODE_TASK, pol, pin, lvl));
      @(negedge clock);
      chk("task_oe", pad_oe[pin], 1'b1);
      chk("init_level", pad_out[pin], lvl);
      @(posedge clock);
      repeat (12) begin
        t = 3'($random(seed));
        tk = 24'($random(seed));
        tk.set[ch] = t[0];
        tk.drive_low_task[ch] = t[1];
        tk.out[ch] = t[2];
        ic_tasks <= tk;
        gp_out <= $random(seed);
        lvl = nxt(t, pol, lvl);
        @(posedge clock);
        ic_tasks <= '0;
        @(negedge clock);
        chk("task_level", pad_out[pin], lvl);
        @(posedge clock);
      end
      // Software task writes: set, then the configurable task, then clear
      apb(1'b1, OFS_TASK_SET, 32'h1 << ch);
      lvl = 1'b1;
      apb(1'b1, OFS_TASK_OUT, 32'h1 << ch);
      lvl = nxt(3'b100, pol, lvl);
      @(negedge clock);
      chk("sw_task", pad_out[pin], lvl);
      @(posedge clock);
      apb(1'b1, OFS_TASK_LOW, 32'h1 << ch);
      lvl = 1'b0;
      @(negedge clock);
      chk("sw_low", pad_out[pin], lvl);
      @(posedge clock);
      apb(1'b1, OFS_CONFIG + 12'(4 * ch), mk(MODE_DISABLED, pol, pin, lvl));
      @(negedge clock);
      chk("port_out", pad_out[pin], gp_out[pin]);
      chk("port_dir", pad_oe[pin], gp_dir[pin]);
      @(posedge clock);
    end
    // Event channels: rising, falling, any change
    gp_out <= 32'h0;
    gp_dir <= 32'hffff_ffff;
    for (p = 1; p < 4; p++) begin
      pin = 5'(20 + p);
      apb(1'b1, OFS_CONFIG + 12'(4 * p), mk(MODE_EVENT, 2'(p), pin, 1'b1));
      apb(1'b1, OFS_INTEN, 32'h1 << p);
      @(negedge clock);
      chk("event_oe", pad_oe[pin], 1'b0);
      @(posedge clock);
      ext_level[pin] <= 1'b1;
      watch(p);
      chk("rise_event", ce, fires(2'(p), 1'b1));
      ext_level[pin] <= 1'b0;
      watch(p);
      chk("fall_event", ce, fires(2'(p), 1'b0));
      chk("irq_set", irq, 1'b1);
      apb(1'b0, OFS_EVENT_IN + 12'(4 * p), 32'h0);
      chk("flag_set", rdata, 32'h1);
      apb(1'b1, OFS_EVENT_IN + 12'(4 * p), 32'h0);
      apb(1'b0, OFS_EVENT_IN + 12'(4 * p), 32'h0);
      chk("flag_clear", rdata, 32'h0);
      chk("irq_clear", irq, 1'b0);
      apb(1'b1, OFS_CONFIG + 12'(4 * p), 32'h0);
    end
    // Port event: pin 4 senses high, pin 5 senses low
    gp_dir <= 32'h0;
    ext_level <= 32'h20;
    apb(1'b1, OFS_INTEN_OFF, 32'h8000_0000);
    apb(1'b1, OFS_SENSE_LO, {20'h0, SENSE_LOW, SENSE_HIGH, 8'h0});
    apb(1'b1, OFS_EVENT_PORT, 32'h1);
    apb(1'b1, OFS_INTEN_SET, 32'h8000_0000);
    idle_sleep <= 1'b1;
    ext_level[4] <= 1'b1;
    watch(0);
    chk("port_rise", cp, 32'h1);
    chk("idle_wake", cw, 32'h1);
    chk("detect_level", detect, 1'b1);
    chk("port_irq", irq, 1'b1);
    apb(1'b0, OFS_EVENT_PORT, 32'h0);
    chk("port_flag", rdata, 32'h1);
    apb(1'b1, OFS_EVENT_PORT, 32'h1);
    apb(1'b0, OFS_EVENT_PORT, 32'h0);
    chk("port_flag_clear", rdata, 32'h0);
    off_request <= 1'b1;
    @(posedge clock);
    off_request <= 1'b0;
    @(negedge clock);
    chk("off_wake", off_wake_reset, 1'b1);
    @(posedge clock);
    ext_level[4] <= 1'b0;
    watch(0);
    chk("port_fall", cp, 32'h0);
    ext_level[5] <= 1'b0;
    watch(0);
    chk("port_low", cp, 32'h1);
    // Entering sleep with detect already high must not wake
    idle_sleep <= 1'b0;
    @(posedge clock);
    idle_sleep <= 1'b1;
    watch(0);
    chk("sleep_high", cw, 32'h0);
    // Latched source: partial clear with a bit still set
    apb(1'b1, OFS_DETECT_MODE, 32'h1);
    ext_level[5] <= 1'b1;
    watch(0);
    apb(1'b1, OFS_LATCH, 32'h10);
    watch(0);
    chk("latch_rearm", cp, 32'h1);
    apb(1'b0, OFS_LATCH, 32'h0);
    chk("latch_left", rdata, 32'h20);
    idle_sleep <= 1'b0;
    complete_run();
  end
endmodule
